//--- pwts_map.svh
// register offsets, field positions and reset values of the time-base block
`ifndef PWTS_MAP_SVH
`define PWTS_MAP_SVH

`define PWTS_TIMEBASE_CONTROL_IDX 6'h00
`define PWTS_STATUS_IDX           6'h01
`define PWTS_PHASE_VALUE_IDX      6'h03
`define PWTS_TIMEBASE_COUNTER_IDX 6'h04
`define PWTS_PERIOD_VALUE_IDX     6'h05
`define PWTS_COMPARE_CONTROL_IDX  6'h07
`define PWTS_COMPARE_A_VALUE_FINE_IDX        6'h08
`define PWTS_COMPARE_A_VALUE_VALUE_IDX       6'h09
`define PWTS_COMPARE_B_VALUE_VALUE_IDX       6'h0A
`define PWTS_COMPARE_A_VALUE_FINE_MIRROR_IDX 6'h2C
`define PWTS_COMPARE_A_VALUE_MIRROR_IDX      6'h2D
`define PWTS_TICK_START_IDX       6'h30

// timebase_control fields
`define PWTS_MODE_LSB      0
`define PWTS_PHASE_EN_BIT  2
`define PWTS_PERIOD_DL_BIT 3
`define PWTS_SWSYNC_BIT    6
`define PWTS_SYNCSEL_LSB   4
`define PWTS_SYNC_DIR_BIT  13
`define PWTS_DCA_SYNC_BIT  8
`define PWTS_DCB_SYNC_BIT  9
`define PWTS_PRESCALE_LSB  10
// compare_control fields
`define PWTS_LOADA_LSB     0
`define PWTS_LOADB_LSB     2
`define PWTS_DIRECTA_BIT   4
`define PWTS_DIRECTB_BIT   6

`define PWTS_TIMEBASE_CONTROL_RESET   16'h0033
`define PWTS_COMPARE_CONTROL_RESET  16'h0000
`define PWTS_PERIOD_RESET  16'h0000

// master-to-slave sync delay when the tick runs at the system clock
`define PWTS_SYNC_DELAY_CYC 2

`endif

//--- pwts_pkg.sv
// types shared by the time-base and compare block
package pwts_pkg;
	typedef enum logic [1:0] {
		PWTS_MODE_UP     = 2'h0,
		PWTS_MODE_DOWN   = 2'h1,
		PWTS_MODE_UPDOWN = 2'h2,
		PWTS_MODE_FROZEN = 2'h3
	} pwts_mode_t;

	typedef enum logic [1:0] {
		PWTS_SYNCO_INPUT = 2'h0,
		PWTS_SYNCO_ZERO  = 2'h1,
		PWTS_SYNCO_COMPARE_B_VALUE  = 2'h2,
		PWTS_SYNCO_OFF   = 2'h3
	} pwts_synco_t;

	typedef enum logic [1:0] {
		PWTS_LOAD_ZERO   = 2'h0,
		PWTS_LOAD_PERIOD = 2'h1,
		PWTS_LOAD_BOTH   = 2'h2,
		PWTS_LOAD_NONE   = 2'h3
	} pwts_load_t;

	typedef enum logic [2:0] {
		PWTS_DIR_UP   = 3'h1,
		PWTS_DIR_DOWN = 3'h2,
		PWTS_DIR_HOLD = 3'h4
	} pwts_dir_t;
endpackage

//--- pwts_compare_channel.sv
// one shadowed compare register with its match detector
`timescale 1ns/10ps
module pwts_compare_channel #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset,
	// software access
	input  wire logic              write,
	input  wire logic [WIDTH-1:0]  writeData,
	input  wire logic              directMode,
	input  wire pwts_pkg::pwts_load_t loadPoint,
	output logic       [WIDTH-1:0] readValue,
	// time-base
	input  wire logic              tick,
	input  wire logic [WIDTH-1:0]  counter,
	input  wire logic              zeroMatch,
	input  wire logic              periodMatch,
	output logic                   match,
	output logic       [WIDTH-1:0] activeValue
);
	import pwts_pkg::*;

	logic [WIDTH-1:0] shadowValue;
	wire loadHere = tick && !directMode &&
		((zeroMatch && (loadPoint == PWTS_LOAD_ZERO ||
			loadPoint == PWTS_LOAD_BOTH)) ||
		(periodMatch && (loadPoint == PWTS_LOAD_PERIOD ||
			loadPoint == PWTS_LOAD_BOTH)));      // R18 R24

	assign readValue = directMode ? activeValue : shadowValue; // R17 R20
	// only the active copy is compared; its next value keeps the match
	// in step with the counter value that is handed in
	wire [WIDTH-1:0] nextActive =
		(write && directMode) ? writeData :
		(loadHere ? shadowValue : activeValue);
	assign match = (counter == nextActive);           // R15 R19

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			shadowValue <= '0;
			activeValue <= '0;
		end else begin
			if (write && !directMode)
				shadowValue <= writeData;             // R17
			if (write && directMode)
				activeValue <= writeData;             // R20
			else if (loadHere)
				activeValue <= shadowValue;           // R18
		end
	end
endmodule

//--- pwts_timebase.sv
// time-base counter with sync chain, global gate and two compare units
`timescale 1ns/10ps
`include "pwts_map.svh"

// Functional notes
// R1 - phase load enable copies phase on sync
// R2 - sync reload happens on next tick edge
// R3 - sync delay two clocks or one tick
// R4 - software force ORed with sync input
// R5 - digital compare events may cause sync
// R6 - up-down direction after sync follows direction bit
// R7 - direction bit ignored in single-direction modes
// R8 - no reload when disabled, pass-through kept
// R9 - sync output from input, zero or compare-B
// R10 - global start gates and aligns all ticks
// R11 - software stops ticks before configuring
// R12 - up, down, up-down and frozen modes
// R13 - count ranges and wrap behaviour per mode
// R14 - period shadow loaded at zero unless direct
// R15 - separate match events for A and B
// R16 - match count per cycle follows mode
// R17 - compare shadow at same address, default on
// R18 - shadow copy on zero, period or both
// R19 - matches only from active compare values
// R20 - direct mode accesses active register
// R21 - skipped matches after sync are normal
// R22 - matches go out with counter direction
// R23 - software force is one-cycle, reads zero
// R24 - small fields with disable code reserved
module pwts_timebase #(
	parameter int WIDTH = 16,
	parameter int PRESCALE_W = 3
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// register port
	input  wire logic [5:0]       address,
	input  wire logic [15:0]      writeData,
	input  wire logic             writeStrobe,
	input  wire logic             readStrobe,
	output logic      [15:0]      readData,
	// sync chain
	input  wire logic             syncInput,
	input  wire logic             digitalCompareAEventOne,
	input  wire logic             digitalCompareBEventOne,
	output logic                  syncOutput,
	// events to the action qualifier
	output logic      [WIDTH-1:0] timebaseCounter,
	output logic                  counterUp,
	output logic                  zeroMatch,
	output logic                  periodMatch,
	output logic                  compareAMatch,
	output logic                  compareBMatch,
	output logic                  timebaseTick
);
	import pwts_pkg::*;

	logic [15:0]           timebaseControl;
	logic [15:0]           compareControl;
	logic [WIDTH-1:0]      phaseValue;
	logic [WIDTH-1:0]      periodActive;
	logic [WIDTH-1:0]      periodShadow;
	logic [15:0]           fineA;
	logic                  globalTickStart;
	logic [PRESCALE_W-1:0] prescaleCount;
	logic                  softSyncPulse;
	logic                  syncPending;
	logic                  counterMax;
	pwts_dir_t             dirState;
	logic [WIDTH-1:0]      cnt;

	// register decode
	wire selCtl   = address == `PWTS_TIMEBASE_CONTROL_IDX;
	wire selSts   = address == `PWTS_STATUS_IDX;
	wire selPhs   = address == `PWTS_PHASE_VALUE_IDX;
	wire selCtr   = address == `PWTS_TIMEBASE_COUNTER_IDX;
	wire selPrd   = address == `PWTS_PERIOD_VALUE_IDX;
	wire selCmpc  = address == `PWTS_COMPARE_CONTROL_IDX;
	wire selFine  = address == `PWTS_COMPARE_A_VALUE_FINE_IDX ||
		address == `PWTS_COMPARE_A_VALUE_FINE_MIRROR_IDX;
	wire selCmpa  = address == `PWTS_COMPARE_A_VALUE_VALUE_IDX ||
		address == `PWTS_COMPARE_A_VALUE_MIRROR_IDX;
	wire selCmpb  = address == `PWTS_COMPARE_B_VALUE_VALUE_IDX;
	wire selStart = address == `PWTS_TICK_START_IDX;

	wire pwts_mode_t mode = pwts_mode_t'(timebaseControl[`PWTS_MODE_LSB +: 2]);
	wire phaseEnable = timebaseControl[`PWTS_PHASE_EN_BIT];
	wire periodDirect = timebaseControl[`PWTS_PERIOD_DL_BIT];
	wire syncDirUp = timebaseControl[`PWTS_SYNC_DIR_BIT];
	wire pwts_synco_t syncSel =
		pwts_synco_t'(timebaseControl[`PWTS_SYNCSEL_LSB +: 2]);
	wire [PRESCALE_W-1:0] prescale =
		timebaseControl[`PWTS_PRESCALE_LSB +: PRESCALE_W];

	// tick: gated by global start; prescaler held at zero while stopped
	// so every module restarts with its first tick on the same edge
	wire tickDue = globalTickStart && (prescaleCount == prescale); // R10
	wire [PRESCALE_W-1:0] prescaleInc =
		PRESCALE_W'(prescaleCount + 1'b1);
	// the tick is a flop, so the counter moves on the edge that sees it
	wire tick = timebaseTick;

	// sync sources; all share the same effect
	wire dcSync = (timebaseControl[`PWTS_DCA_SYNC_BIT] &&
		digitalCompareAEventOne) ||
		(timebaseControl[`PWTS_DCB_SYNC_BIT] &&
		digitalCompareBEventOne);                                  // R5
	wire syncEvent = syncInput || softSyncPulse || dcSync;         // R4
	// a pending pulse waits for the next tick edge
	wire syncNow = (syncEvent || syncPending) && tick;             // R2 R3
	// a frozen counter stays put; a phase jump may skip a compare
	// event, and that event is not made up afterwards
	wire syncLoad = syncNow && phaseEnable &&
		(mode != PWTS_MODE_FROZEN);                         // R1 R8 R21

	// counter conditions
	wire atZero = (cnt == '0);
	wire atPeriod = (cnt == periodActive);
	wire abovePeriod = (cnt >= periodActive);
	wire atMax = (cnt == '1);
	wire [WIDTH-1:0] cntInc = WIDTH'(cnt + 1'b1);
	wire [WIDTH-1:0] cntDec = WIDTH'(cnt - 1'b1);

	// direction taken right after a sync load; only up-down asks the bit
	wire pwts_dir_t syncDir =
		(mode == PWTS_MODE_DOWN) ? PWTS_DIR_DOWN :
		(mode == PWTS_MODE_UPDOWN && !syncDirUp) ? PWTS_DIR_DOWN :
		PWTS_DIR_UP;                                               // R6 R7

	// register write decode
	wire wrCtl   = writeStrobe && selCtl;
	wire wrSts   = writeStrobe && selSts;
	wire wrPhs   = writeStrobe && selPhs;
	wire wrCtr   = writeStrobe && selCtr;
	wire wrPrd   = writeStrobe && selPrd;
	wire wrCmpc  = writeStrobe && selCmpc;
	wire wrFine  = writeStrobe && selFine;
	wire wrCmpa  = writeStrobe && selCmpa;
	wire wrCmpb  = writeStrobe && selCmpb;
	wire wrStart = writeStrobe && selStart;

	// the force bit is never stored, so it always reads back as zero
	wire [15:0] swMask = 16'h0001 << `PWTS_SWSYNC_BIT;
	wire [15:0] ctlStored = writeData & ~swMask;                   // R23
	wire forceSync = wrCtl && writeData[`PWTS_SWSYNC_BIT];         // R23
	// status: bit 0 direction, bit 1 sticky counter-at-max flag
	wire clrMax = wrSts && writeData[1];

	// period: shadow copied to active at zero unless direct
	wire periodLoad = tick && atZero && !periodDirect;             // R14
	wire [WIDTH-1:0] nextPeriodActive =
		(wrPrd && periodDirect) ? writeData[WIDTH-1:0] :
		periodLoad ? periodShadow :
		periodActive;                                              // R14
	wire [WIDTH-1:0] periodRead =
		periodDirect ? periodActive : periodShadow;                // R14

	// compare control fields
	wire pwts_load_t loadPointA =
		pwts_load_t'(compareControl[`PWTS_LOADA_LSB +: 2]);        // R18
	wire pwts_load_t loadPointB =
		pwts_load_t'(compareControl[`PWTS_LOADB_LSB +: 2]);        // R18
	wire directA = compareControl[`PWTS_DIRECTA_BIT];              // R20
	wire directB = compareControl[`PWTS_DIRECTB_BIT];              // R20

	logic [WIDTH-1:0]      next_cnt;
	pwts_dir_t             next_dirState;
	logic [WIDTH-1:0]      readValueA;
	logic [WIDTH-1:0]      readValueB;
	logic [WIDTH-1:0]      activeB;
	logic                  matchA;
	logic                  matchB;

	// the units compare against the next counter value, so the
	// registered match events line up with the counter output
	pwts_compare_channel #(
		.WIDTH (WIDTH)
	) u_compareA (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.write       (wrCmpa),
		.writeData   (writeData[WIDTH-1:0]),
		.directMode  (directA),
		.loadPoint   (loadPointA),
		.readValue   (readValueA),
		.tick        (tick),
		.counter     (next_cnt),
		.zeroMatch   (atZero),
		.periodMatch (atPeriod),
		.match       (matchA),
		.activeValue ()
	);

	pwts_compare_channel #(
		.WIDTH (WIDTH)
	) u_compareB (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.write       (wrCmpb),
		.writeData   (writeData[WIDTH-1:0]),
		.directMode  (directB),
		.loadPoint   (loadPointB),
		.readValue   (readValueB),
		.tick        (tick),
		.counter     (next_cnt),
		.zeroMatch   (atZero),
		.periodMatch (atPeriod),
		.match       (matchB),
		.activeValue (activeB)
	);

	// sync output source; the input path passes through even when
	// the phase load is off, so downstream modules still follow
	wire syncOutNext =
		(syncSel == PWTS_SYNCO_INPUT) ? syncEvent :
		(syncSel == PWTS_SYNCO_ZERO) ? (tick && atZero) :
		(syncSel == PWTS_SYNCO_COMPARE_B_VALUE) ? (tick && cnt == activeB) :
		1'b0;                                                   // R8 R9 R24

	// read mux
	wire [15:0] statusWord = {14'h0000, counterMax, counterUp};
	wire [15:0] readMux =
		selCtl   ? timebaseControl :
		selSts   ? statusWord :
		selPhs   ? 16'(phaseValue) :
		selCtr   ? 16'(cnt) :
		selPrd   ? 16'(periodRead) :
		selCmpc  ? compareControl :
		selFine  ? fineA :
		selCmpa  ? 16'(readValueA) :                           // R17 R20
		selCmpb  ? 16'(readValueB) :                           // R17 R20
		selStart ? {15'h0000, globalTickStart} :
		16'h0000;

	assign timebaseCounter = cnt;

	// counter next state
	always_comb begin
		next_cnt = cnt;
		next_dirState = dirState;
		if (tick) begin
			case (mode)                                            // R12 R13
				PWTS_MODE_UP: begin
					next_dirState = PWTS_DIR_UP;
					next_cnt = abovePeriod ? '0 : cntInc;
				end
				PWTS_MODE_DOWN: begin
					next_dirState = PWTS_DIR_DOWN;
					next_cnt = atZero ? periodActive : cntDec;
				end
				PWTS_MODE_UPDOWN: begin
					case (dirState)
						PWTS_DIR_DOWN: begin
							if (atZero) begin
								next_dirState = PWTS_DIR_UP;
								next_cnt = cntInc;
							end else begin
								next_cnt = cntDec;
							end
						end
						default: begin
							if (abovePeriod) begin
								next_dirState = PWTS_DIR_DOWN;
								next_cnt = cntDec;
							end else begin
								next_dirState = PWTS_DIR_UP;
								next_cnt = cntInc;
							end
						end
					endcase
				end
				default: begin
					next_dirState = PWTS_DIR_HOLD;
				end
			endcase
			if (syncLoad) begin
				next_cnt = phaseValue;                             // R1 R2
				next_dirState = syncDir;                           // R6 R7
			end
		end
		// a software write to the counter wins over counting
		if (wrCtr) begin
			next_cnt = writeData[WIDTH-1:0];
		end
	end

	// prescaler and tick
	always_ff @(posedge ref_clk) begin
		if (reset || !globalTickStart) begin
			prescaleCount <= '0;
			timebaseTick <= 1'b0;                                  // R10
		end else begin
			prescaleCount <= tickDue ? '0 : prescaleInc;
			timebaseTick <= tickDue;                               // R10
		end
	end

	// control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timebaseControl <= `PWTS_TIMEBASE_CONTROL_RESET;
			compareControl <= `PWTS_COMPARE_CONTROL_RESET;
			phaseValue <= '0;
			fineA <= '0;
			globalTickStart <= 1'b0;                               // R10
			softSyncPulse <= 1'b0;
		end else begin
			if (wrCtl)
				timebaseControl <= ctlStored;
			if (wrCmpc)
				compareControl <= writeData;
			if (wrPhs)
				phaseValue <= writeData[WIDTH-1:0];
			if (wrFine)
				fineA <= writeData;
			if (wrStart)
				globalTickStart <= writeData[0];                   // R10
			softSyncPulse <= forceSync;                            // R4 R23
		end
	end

	// period registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			periodActive <= WIDTH'(`PWTS_PERIOD_RESET);
			periodShadow <= WIDTH'(`PWTS_PERIOD_RESET);
		end else begin
			periodActive <= nextPeriodActive;                      // R14
			if (wrPrd && !periodDirect)
				periodShadow <= writeData[WIDTH-1:0];              // R14
		end
	end

	// counter and direction
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt <= '0;
			dirState <= PWTS_DIR_HOLD;
			counterUp <= 1'b0;
		end else begin
			cnt <= next_cnt;
			dirState <= next_dirState;
			counterUp <= (next_dirState == PWTS_DIR_UP);           // R22
		end
	end

	// sync bookkeeping; a set and a clear in one cycle keep the set
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			syncPending <= 1'b0;
			syncOutput <= 1'b0;
			counterMax <= 1'b0;
		end else begin
			if (syncEvent && !tick)
				syncPending <= 1'b1;                               // R2
			else if (tick)
				syncPending <= 1'b0;
			syncOutput <= syncOutNext;                             // R9
			if (atMax)
				counterMax <= 1'b1;
			else if (clrMax)
				counterMax <= 1'b0;
		end
	end

	// events for the action qualifier, aligned with the counter output
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			zeroMatch <= 1'b0;
			periodMatch <= 1'b0;
			compareAMatch <= 1'b0;
			compareBMatch <= 1'b0;
		end else begin
			zeroMatch <= (next_cnt == '0);
			periodMatch <= (next_cnt == nextPeriodActive);
			compareAMatch <= matchA;                               // R15 R16
			compareBMatch <= matchB;                               // R15 R16
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			readData <= '0;
		end else if (readStrobe) begin
			readData <= readMux;
		end else begin
			readData <= '0;
		end
	end
endmodule

//--- pwts_sync_peer.sv
// upstream master: one-cycle sync and compare-event pulses
`timescale 1ns/10ps
module pwts_sync_peer (
	// bench request in, pulses out to the block
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic [2:0] fire,
	output logic            syncInput,
	output logic            dcAEvent,
	output logic            dcBEvent
);
	always_ff @(posedge ref_clk)
		{dcBEvent, dcAEvent, syncInput} <= reset ? 3'h0 : fire;
endmodule

//--- pwts_timebase_props.sv
// port assertions for the time-base block
`timescale 1ns/10ps
`include "pwts_map.svh"
module pwts_timebase_props #(
	parameter int WIDTH = 16
) (
	// watched ports
	input wire logic             ref_clk,
	input wire logic             reset,
	input wire logic [5:0]       address,
	input wire logic             writeStrobe,
	input wire logic             readStrobe,
	input wire logic [15:0]      readData,
	input wire logic             syncOutput,
	input wire logic [WIDTH-1:0] timebaseCounter,
	input wire logic             zeroMatch,
	input wire logic             compareAMatch,
	input wire logic             compareBMatch,
	input wire logic             timebaseTick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_TICK_OFF: assert property ($past(reset) |-> !timebaseTick)
		else $error("tick early");
	AST_SYNC_OFF: assert property ($past(reset) |-> !syncOutput)
		else $error("sync out early");
	AST_CNT_RST: assert property ($past(reset) |-> timebaseCounter == 0)
		else $error("counter not cleared");
	AST_HOLD: assert property (!timebaseTick && !writeStrobe
		|=> $stable(timebaseCounter)) else $error("counter moved");
	AST_ZERO: assert property (zeroMatch |-> timebaseCounter == 0)
		else $error("zero match off zero");
	AST_SWF_RD: assert property (readStrobe && address ==
		`PWTS_TIMEBASE_CONTROL_IDX |=> !readData[`PWTS_SWSYNC_BIT])
		else $error("force bit reads one");
	AST_A_HOLD: assert property (compareAMatch && !timebaseTick
		&& !writeStrobe |=> compareAMatch) else $error("A match lost");
	AST_B_HOLD: assert property (compareBMatch && !timebaseTick
		&& !writeStrobe |=> compareBMatch) else $error("B match lost");
	cover property (compareAMatch && timebaseTick);
	cover property (syncOutput);
	cover property (zeroMatch && timebaseTick);
endmodule
bind pwts_timebase pwts_timebase_props #(.WIDTH(WIDTH)) u_props (.ref_clk,
	.reset, .address, .writeStrobe, .readStrobe, .readData, .syncOutput,
	.timebaseCounter, .zeroMatch, .compareAMatch, .compareBMatch,
	.timebaseTick);

//--- tb_pwts_timebase.sv
// self-checking bench for the time-base block
`timescale 1ns/10ps
`include "pwts_map.svh"
module tb_pwts_timebase;
	localparam logic [5:0] CTL = `PWTS_TIMEBASE_CONTROL_IDX;
	logic        ref_clk, reset, writeStrobe, readStrobe, syncInput;
	logic        syncOutput, counterUp, zeroMatch, periodMatch, dcAEvent;
	logic        compareAMatch, compareBMatch, timebaseTick, dcBEvent;
	logic [5:0]  address;
	logic [15:0] writeData, readData, cnt;
	logic [2:0]  fire;
	int          bad_count, n_compared, i;
	pwts_timebase dut (.ref_clk, .reset, .address, .writeData, .writeStrobe,
		.readStrobe, .readData, .syncInput,
		.digitalCompareAEventOne(dcAEvent),
		.digitalCompareBEventOne(dcBEvent), .syncOutput,
		.timebaseCounter(cnt), .counterUp, .zeroMatch, .periodMatch,
		.compareAMatch, .compareBMatch, .timebaseTick);
	pwts_sync_peer peer (.ref_clk, .reset, .fire, .syncInput, .dcAEvent,
		.dcBEvent);
	task automatic stop_test();
		if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic lim(input int n, m);
		if (n >= m) begin
			bad_count++;
			stop_test();
		end
	endtask
	// read data is taken in the one cycle where it stands
	task automatic acc(input logic w, logic [5:0] a, logic [15:0] d);
		@(posedge ref_clk);
		address <= a;
		writeData <= d;
		{writeStrobe, readStrobe} <= {w, !w};
		@(posedge ref_clk);
		{writeStrobe, readStrobe} <= 2'h0;
		@(negedge ref_clk);
		if (!w) chk(readData, d);
	endtask
	task automatic wc(input logic [15:0] v, input int m);
		for (i = 0; i < m && cnt !== v; i++) @(negedge ref_clk);
		lim(i, m);
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge ref_clk);
		fire <= m;
		@(posedge ref_clk);
		fire <= 3'h0;
	endtask
	task automatic s_reset();
		acc(0, CTL, `PWTS_TIMEBASE_CONTROL_RESET);
		acc(0, `PWTS_COMPARE_CONTROL_IDX, `PWTS_COMPARE_CONTROL_RESET);
		acc(0, 6'h3F, 16'h0000);
		chk(cnt, 16'h0000);
	endtask
	task automatic s_start();
		acc(1, CTL, 16'h030C);
		acc(1, `PWTS_PERIOD_VALUE_IDX, 16'h0040);
		acc(1, `PWTS_PHASE_VALUE_IDX, 16'h0030);
		acc(1, `PWTS_TICK_START_IDX, 16'h0001);
		wc(16'h0005, 20);
		chk({15'h0, counterUp}, 16'h0001);
		chk({15'h0, timebaseTick}, 16'h0001);
		wc(16'h0040, 80);
		chk({15'h0, periodMatch}, 16'h0001);
		@(negedge ref_clk);
		chk(cnt, 16'h0000);
		chk({15'h0, zeroMatch}, 16'h0001);
	endtask
	// up-down sync: direction after the load follows the direction bit
	task automatic s_dir();
		for (int k = 0; k < 2; k++) begin
			acc(1, CTL, (k == 1) ? 16'h200E : 16'h000E);
			wc(16'h0002, 200);
			pulse(3'h1);
			wc(16'h0030, 3);
			@(negedge ref_clk);
			chk(cnt, (k == 1) ? 16'h0031 : 16'h002F);
			chk({15'h0, counterUp}, {15'h0, k[0]});
		end
	endtask
	// force, sync input, then both compare events reload the phase
	task automatic s_sync();
		for (int k = 0; k < 4; k++) begin
			wc(16'h0002, 100);
			if (k == 0) acc(1, CTL, 16'h034C);
			else pulse(3'(1 << (k - 1)));
			wc(16'h0030, 3);
		end
	endtask
	task automatic s_pass();
		acc(1, CTL, 16'h0008);
		wc(16'h0002, 100);
		pulse(3'h1);
		for (i = 0; i < 4 && syncOutput !== 1'b1; i++) @(negedge ref_clk);
		lim(i, 4);
		chk({15'h0, cnt < 16'h0010}, 16'h0001);
	endtask
	task automatic s_cmp();
		acc(1, `PWTS_COMPARE_CONTROL_IDX, 16'h0010);
		acc(1, `PWTS_COMPARE_A_VALUE_VALUE_IDX, 16'h0007);
		acc(0, `PWTS_COMPARE_A_VALUE_VALUE_IDX, 16'h0007);
		wc(16'h0007, 100);
		chk({15'h0, compareAMatch}, 16'h0001);
		acc(1, `PWTS_COMPARE_B_VALUE_VALUE_IDX, 16'h0009);
		wc(16'h0009, 20);
		chk({15'h0, compareBMatch}, 16'h0000);
		wc(16'h0001, 100);
		wc(16'h0009, 20);
		chk({15'h0, compareBMatch}, 16'h0001);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		{reset, writeStrobe, readStrobe, fire} = 6'h20;
		{address, writeData} = 22'h0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		s_reset();
		s_start();
		s_sync();
		s_pass();
		s_cmp();
		s_dir();
		stop_test();
	end
endmodule
